// ==== shared/capcom_pkg.sv ====
package capcom_pkg;

  localparam int NCH = 16;
  localparam int NPAIR = 8;

  // Register byte offsets; channel blocks step by one word.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RELOAD_A = 8'h04;
  localparam logic [7:0] OFF_RELOAD_B = 8'h08;
  localparam logic [7:0] OFF_TIMER_A = 8'h0C;
  localparam logic [7:0] OFF_TIMER_B = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_ARM = 8'h18;
  localparam logic [7:0] OFF_DOUBLE = 8'h1C;
  localparam logic [1:0] BLK_CFG = 2'h1;
  localparam logic [1:0] BLK_VAL = 2'h2;

  // Control register field positions.
  localparam int CTRL_RUN_A = 0;
  localparam int CTRL_RUN_B = 1;
  localparam int CTRL_SEL_A = 4;
  localparam int CTRL_SEL_B = 8;
  localparam int CTRL_STAGGER = 12;
  localparam logic [15:0] CTRL_MASK = 16'h1773;

  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [15:0] CCVAL_RST = 16'h0000;
  localparam logic [15:0] ARM_RST = 16'hFFFF;

  // Timing: counter top and staggered slot phase.
  localparam logic [15:0] TB_TOP = 16'hFFFF;
  localparam logic [2:0] STAGGER_SLOT = 3'h7;

  // Clock source selects above the prescaler divides.
  localparam logic [2:0] SEL_GP_TIMER = 3'h6;
  localparam logic [2:0] SEL_EXT_COUNT = 3'h7;

  typedef enum logic [2:0] {
    MODE_OFF, CAP_RISE, CAP_FALL, CAP_BOTH,
    CMP_0, CMP_1, CMP_2, CMP_3
  } cc_mode_t;

  // Channel configuration word, bits 4:0 of its register.
  typedef struct packed {
    logic single;
    logic tsel;
    cc_mode_t mode;
  } chcfg_t;

endpackage

// ==== hdl/cc_word_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module cc_word_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] cap_we,
  input wire logic [15:0][15:0] cap_data,
  input wire logic bus_we,
  input wire logic [3:0] bus_idx,
  input wire logic [15:0] bus_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0][15:0] words,
  output logic [15:0] rd_data
);
  logic [15:0][15:0] mem_q;
  logic [15:0] rd_q;

  // A capture wins over a bus write to the same word, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q <= {capcom_pkg::NCH{capcom_pkg::CCVAL_RST}};
    end else begin
      for (int i = 0; i < capcom_pkg::NCH; i++) begin
        if (cap_we[i]) begin
          mem_q[i] <= cap_data[i];
        end else if (bus_we && bus_idx == 4'(i)) begin
          mem_q[i] <= bus_data;
        end
      end
    end
  end

  // Registered read port for the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= capcom_pkg::CCVAL_RST;
    end else begin
      rd_q <= mem_q[rd_idx];
    end
  end

  assign words = mem_q;
  assign rd_data = rd_q;
endmodule
`default_nettype wire

// ==== hdl/capture_compare_unit.sv ====
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gp_timer_ovf,
  input wire logic ext_count_in,
  input wire logic [15:0] cc_pin_in,
  output logic [15:0] cc_pin_out,
  output logic [15:0] cc_pin_oe,
  output logic [15:0] cc_irq_req
);
  logic [15:0] ctrl_q;
  logic [1:0][15:0] reload_q;
  logic [1:0][15:0] tb_q;
  logic [1:0] tick;
  logic [1:0] tick_q;
  logic [1:0] ovf_q;
  logic [4:0] pre_q;
  capcom_pkg::chcfg_t [15:0] cfg_q;
  logic [7:0] dbl_q;
  logic [15:0] flag_q;
  logic [15:0] armed_q;
  logic [15:0] done_q;
  logic [15:0] pin_q;
  logic [15:0] pin_d;
  logic [15:0] oe_q;
  logic [15:0] oe_d;
  logic [15:0] irq_q;
  logic [15:0] hit;
  logic [15:0] capev;
  logic [15:0] ovf_ch;
  logic [15:0] once;
  logic [15:0][15:0] words;
  logic [15:0][15:0] cap_data;
  logic [15:0] mem_rd;
  logic [15:0] in_s1;
  logic [15:0] in_s2;
  logic [15:0] in_s3;
  logic [2:0] ext_s;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;
  logic wr;
  logic in_cfg;
  logic in_val;
  logic mapped;
  logic [3:0] idx;
  logic ext_tick;
  logic stag_ok;

  // True when the low sel bits of the prescaler are all ones; selects 6 and 7 pass the outside timer pulse or count edge instead.
  function automatic logic sel_tick(input logic [2:0] sel, input logic [4:0] pre,
                                    input logic gp, input logic ext);
    logic [4:0] mask;
    mask = 5'((6'h01 << sel) - 6'h01);
    case (sel)
      capcom_pkg::SEL_GP_TIMER: sel_tick = gp;
      capcom_pkg::SEL_EXT_COUNT: sel_tick = ext;
      default: sel_tick = ((pre & mask) == mask);
    endcase
  endfunction

  // Bus decode: one wait state, the access completes when pready is high.
  assign acc = psel && penable && !pready_q;
  assign wr = psel && penable && pready_q && pwrite;
  assign in_cfg = (paddr[7:6] == capcom_pkg::BLK_CFG);
  assign in_val = (paddr[7:6] == capcom_pkg::BLK_VAL);
  assign idx = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'h0) && (in_cfg || in_val || paddr[7:5] == 3'h0);

  // Pins and the count input come from outside; two flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1 <= 16'h0000;
      in_s2 <= 16'h0000;
      in_s3 <= 16'h0000;
      ext_s <= 3'h0;
    end else begin
      in_s1 <= cc_pin_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      ext_s <= {ext_s[1:0], ext_count_in};
    end
  end

  assign ext_tick = ext_s[1] && !ext_s[2];

  // Staggered operation lets a time base advance only in one slot of eight.
  assign stag_ok = !ctrl_q[capcom_pkg::CTRL_STAGGER] || (pre_q[2:0] == capcom_pkg::STAGGER_SLOT);

  // Clock selection for each time base.
  always_comb begin
    tick[0] = ctrl_q[capcom_pkg::CTRL_RUN_A] && stag_ok &&
              sel_tick(ctrl_q[capcom_pkg::CTRL_SEL_A +: 3], pre_q, gp_timer_ovf, ext_tick);
    tick[1] = ctrl_q[capcom_pkg::CTRL_RUN_B] && stag_ok &&
              sel_tick(ctrl_q[capcom_pkg::CTRL_SEL_B +: 3], pre_q, gp_timer_ovf, ext_tick);
  end

  // Free-running prescaler shared by both time bases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end

  // Time bases count up and restart from their reload value after the top.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_q <= {2{capcom_pkg::TIMER_RST}};
      tick_q <= 2'h0;
      ovf_q <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        tick_q[b] <= tick[b];
        ovf_q[b] <= tick[b] && (tb_q[b] == capcom_pkg::TB_TOP);
        if (wr && paddr == (b == 0 ? capcom_pkg::OFF_TIMER_A : capcom_pkg::OFF_TIMER_B)) begin
          tb_q[b] <= pwdata[15:0];
        end else if (tick[b] && tb_q[b] == capcom_pkg::TB_TOP) begin
          tb_q[b] <= reload_q[b];
        end else if (tick[b]) begin
          tb_q[b] <= tb_q[b] + 16'h0001;
        end
      end
    end
  end

  // Software-held configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= capcom_pkg::CTRL_RST;
      reload_q <= {2{capcom_pkg::RELOAD_RST}};
      dbl_q <= 8'h00;
      cfg_q <= '0;
    end else if (wr) begin
      if (paddr == capcom_pkg::OFF_CTRL) begin
        ctrl_q <= pwdata[15:0] & capcom_pkg::CTRL_MASK;
      end
      if (paddr == capcom_pkg::OFF_RELOAD_A) begin
        reload_q[0] <= pwdata[15:0];
      end
      if (paddr == capcom_pkg::OFF_RELOAD_B) begin
        reload_q[1] <= pwdata[15:0];
      end
      if (paddr == capcom_pkg::OFF_DOUBLE) begin
        dbl_q <= pwdata[7:0];
      end
      if (in_cfg && paddr[1:0] == 2'h0) begin
        cfg_q[idx] <= capcom_pkg::chcfg_t'(pwdata[4:0]);
      end
    end
  end

  // Per-channel events: capture edges and compare matches.
  always_comb begin
    for (int c = 0; c < capcom_pkg::NCH; c++) begin
      logic b;
      logic rise;
      logic fall;
      b = cfg_q[c].tsel;
      rise = in_s2[c] && !in_s3[c];
      fall = !in_s2[c] && in_s3[c];
      cap_data[c] = tb_q[b];
      ovf_ch[c] = ovf_q[b];
      once[c] = (cfg_q[c].mode == capcom_pkg::CMP_2) || (cfg_q[c].mode == capcom_pkg::CMP_3);
      case (cfg_q[c].mode)
        capcom_pkg::CAP_RISE: capev[c] = rise;
        capcom_pkg::CAP_FALL: capev[c] = fall;
        capcom_pkg::CAP_BOTH: capev[c] = rise || fall;
        default: capev[c] = 1'b0;
      endcase
      hit[c] = cfg_q[c].mode[2] && tick_q[b] && (words[c] == tb_q[b]) &&
               armed_q[c] && !(once[c] && done_q[c]);
    end
  end

  // Pin drive: toggle, set/clear, or the shared toggle of a register pair.
  always_comb begin
    pin_d = pin_q;
    oe_d = 16'h0000;
    for (int c = 0; c < capcom_pkg::NCH; c++) begin
      if (c < capcom_pkg::NPAIR && dbl_q[c % capcom_pkg::NPAIR]) begin
        oe_d[c] = 1'b1;
        if (hit[c] ^ hit[c + capcom_pkg::NPAIR]) begin
          pin_d[c] = !pin_q[c];
        end
      end else if (c >= capcom_pkg::NPAIR && dbl_q[c % capcom_pkg::NPAIR]) begin
        oe_d[c] = 1'b0;
      end else if (cfg_q[c].mode == capcom_pkg::CMP_1) begin
        oe_d[c] = 1'b1;
        if (hit[c]) begin
          pin_d[c] = !pin_q[c];
        end
      end else if (cfg_q[c].mode == capcom_pkg::CMP_3) begin
        oe_d[c] = 1'b1;
        if (hit[c]) begin
          pin_d[c] = 1'b1;
        end else if (ovf_ch[c]) begin
          pin_d[c] = 1'b0;
        end
      end
    end
  end

  // Pin and request registers; modes 0 and 2 leave the pin alone except on the low channel of a register pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 16'h0000;
      oe_q <= 16'h0000;
      irq_q <= 16'h0000;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
      irq_q <= hit | capev;
    end
  end

  // Sticky flags: a new event beats a write-one-to-clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 16'h0000;
    end else begin
      flag_q <= (flag_q & ~((wr && paddr == capcom_pkg::OFF_FLAGS) ? pwdata[15:0] : 16'h0000))
                | hit | capev;
    end
  end

  // Once-per-period lock is released by the assigned timer's overflow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 16'h0000;
    end else begin
      done_q <= (done_q & ~ovf_ch) | (hit & once);
    end
  end

  // Single-event channels disarm after one compare match; a match disarming wins over a rearm.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= capcom_pkg::ARM_RST;
    end else begin
      for (int c = 0; c < capcom_pkg::NCH; c++) begin
        if (hit[c] && cfg_q[c].single) begin
          armed_q[c] <= 1'b0;
        end else if (wr && paddr == capcom_pkg::OFF_ARM && pwdata[c]) begin
          armed_q[c] <= 1'b1;
        end
      end
    end
  end

  cc_word_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .cap_we(capev),
    .cap_data(cap_data),
    .bus_we(wr && in_val && paddr[1:0] == 2'h0),
    .bus_idx(idx),
    .bus_data(pwdata[15:0]),
    .rd_idx(idx),
    .words(words),
    .rd_data(mem_rd)
  );

  // Read data are registered in the first access cycle, with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && !mapped;
      if (acc && !pwrite) begin
        if (in_cfg) begin
          prdata_q <= {27'h0, cfg_q[idx]};
        end else if (in_val) begin
          prdata_q <= {16'h0000, mem_rd};
        end else begin
          case (paddr)
            capcom_pkg::OFF_CTRL: prdata_q <= {16'h0000, ctrl_q};
            capcom_pkg::OFF_RELOAD_A: prdata_q <= {16'h0000, reload_q[0]};
            capcom_pkg::OFF_RELOAD_B: prdata_q <= {16'h0000, reload_q[1]};
            capcom_pkg::OFF_TIMER_A: prdata_q <= {16'h0000, tb_q[0]};
            capcom_pkg::OFF_TIMER_B: prdata_q <= {16'h0000, tb_q[1]};
            capcom_pkg::OFF_FLAGS: prdata_q <= {16'h0000, flag_q};
            capcom_pkg::OFF_ARM: prdata_q <= {16'h0000, armed_q};
            capcom_pkg::OFF_DOUBLE: prdata_q <= {24'h000000, dbl_q};
            default: prdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cc_pin_out = pin_q;
  assign cc_pin_oe = oe_q;
  assign cc_irq_req = irq_q;

  // Each check watches timer A or a channel that the bench drives in that mode; all channels share the logic.
  property p_stagger_slot;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[capcom_pkg::CTRL_STAGGER] && tick[0] |-> pre_q[2:0] == capcom_pkg::STAGGER_SLOT;
  endproperty
  a_stagger_slot: assert property (p_stagger_slot) else $error("staggered tick off slot");

  property p_count_up;
    @(posedge pclk) disable iff (!presetn)
      tick[0] && tb_q[0] != capcom_pkg::TB_TOP && !wr |=> tb_q[0] == $past(tb_q[0]) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("time base did not advance");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      ovf_q[0] && !$past(wr) |-> tb_q[0] == $past(reload_q[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("overflow did not reload");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      capev[1] |=> words[1] == $past(cap_data[1]) && irq_q[1] && flag_q[1];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost value or request");

  property p_rise_only;
    @(posedge pclk) disable iff (!presetn)
      cfg_q[1].mode == capcom_pkg::CAP_RISE && capev[1] |-> in_s2[1] && !in_s3[1];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("capture on wrong edge");

  property p_mode1_toggle;
    @(posedge pclk) disable iff (!presetn)
      hit[5] && !dbl_q[5] && cfg_q[5].mode == capcom_pkg::CMP_1 |=> pin_q[5] != $past(pin_q[5]);
  endproperty
  a_mode1_toggle: assert property (p_mode1_toggle) else $error("mode 1 pin did not toggle");

  property p_mode0_quiet;
    @(posedge pclk) disable iff (!presetn)
      !dbl_q[4] && cfg_q[4].mode == capcom_pkg::CMP_0 |=> $stable(pin_q[4]) && irq_q[4] == $past(hit[4]);
  endproperty
  a_mode0_quiet: assert property (p_mode0_quiet) else $error("mode 0 touched the pin");

  property p_mode3_pin;
    @(posedge pclk) disable iff (!presetn)
      !dbl_q[7] && cfg_q[7].mode == capcom_pkg::CMP_3 && (hit[7] || ovf_ch[7]) |=> pin_q[7] == $past(hit[7]);
  endproperty
  a_mode3_pin: assert property (p_mode3_pin) else $error("mode 3 pin wrong");

  property p_once_period;
    @(posedge pclk) disable iff (!presetn)
      hit[6] && once[6] ##1 !ovf_ch[6] |-> !hit[6];
  endproperty
  a_once_period: assert property (p_once_period) else $error("second match in one period");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      hit[8] && cfg_q[8].single |=> !armed_q[8] ##1 !hit[8];
  endproperty
  a_single: assert property (p_single) else $error("single event repeated");
endmodule
`default_nettype wire

// ==== test/pin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side of the pins: capture levels and the two outside timer clock sources.
module pin_partner (
  input wire logic pclk,
  output logic [15:0] pin_lvl,
  output logic gp_ovf,
  output logic ext_cnt
);
  // All lines idle low; every change lands just after a rising edge.
  initial begin
    pin_lvl = 16'h0000;
    gp_ovf = 1'b0;
    ext_cnt = 1'b0;
  end
  // Single-cycle overflow pulses with gaps, as an outside timer gives them.
  task automatic gp_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      gp_ovf <= 1'b1;
      @(posedge pclk);
      gp_ovf <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  // Each level is held four cycles so the input synchroniser cannot miss it.
  task automatic ext_edges(input int n);
    repeat (2 * n) begin
      @(posedge pclk);
      ext_cnt <= ~ext_cnt;
      repeat (3) @(posedge pclk);
    end
  endtask
  // A capture trigger: one pin moves to a level and stays there.
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge pclk);
    pin_lvl[ch] <= lvl;
  endtask
endmodule
`default_nettype wire

// ==== test/capture_compare_array_16ch_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module capture_compare_array_16ch_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gp_ovf, ext_cnt, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pin_lvl, pin_in, cc_pin_out, cc_pin_oe, cc_irq_req, t0, v;
  logic [31:0] lfsr_q = 32'h7B8AECED;
  int err_count = 0;
  int check_count = 0;
  int irq_all, cap_exp;
  int irq_n[16];
  int tog_n[16];
  int ch_l[7] = '{2, 10, 4, 5, 6, 7, 8};
  int cfg_l[7] = '{4, 4, 4, 5, 6, 7, 20};
  int off_l[7] = '{11, 13, 10, 12, 14, 16, 15};

  // A driven pin shows the unit's level; otherwise the partner's.
  assign pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & pin_lvl);

  capture_compare_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gp_timer_ovf(gp_ovf), .ext_count_in(ext_cnt), .cc_pin_in(pin_in),
    .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_irq_req(cc_irq_req));
  pin_partner i_partner (.pclk(pclk), .pin_lvl(pin_lvl), .gp_ovf(gp_ovf), .ext_cnt(ext_cnt));

  // Free-running 25 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One APB transfer; pready, read data and error are taken at the rising edge that completes it.
  // Values read just after an edge are those the design held at that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("pready", 1, pready);
        test_done();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts interrupt pulses and pin changes per channel over a fixed span.
  task automatic watch(input int cycles);
    logic [15:0] last;
    last = cc_pin_out;
    irq_all = 0;
    for (int c = 0; c < 16; c++) begin
      irq_n[c] = 0;
      tog_n[c] = 0;
    end
    repeat (cycles) begin
      @(negedge pclk);
      for (int c = 0; c < 16; c++) begin
        irq_n[c] += cc_irq_req[c];
        irq_all += cc_irq_req[c];
        tog_n[c] += (cc_pin_out[c] != last[c]);
      end
      last = cc_pin_out;
    end
  endtask

  // One capture edge on channel 1 with timer B stopped at a random value.
  task automatic cap_edge(input int m, input logic lvl);
    int hit;
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q[15:0];
    apb(1'b1, 8'h10, {16'h0000, v});
    i_partner.set_pin(1, lvl);
    watch(8);
    hit = lvl ? (m != 2) : (m != 1);
    if (hit != 0) cap_exp = v;
    chk("capture irq", hit, irq_n[1]);
    chk("irq of others", hit, irq_all);
    apb(1'b0, 8'h84, 32'h0);
    chk("captured value", cap_exp, rd);
  endtask

  initial begin
    int ei, et;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, reserved bits and an unmapped address.
    apb(1'b0, 8'h18, 32'h0);
    chk("arm reset", 32'h0000FFFF, rd);
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl mask", 32'h00001773, rd);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    $display("Registers done");
    // Timer B counts outside timer pulses, then outside count edges.
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h602);
    i_partner.gp_pulses(5);
    apb(1'b0, 8'h10, 32'h0);
    chk("gp clocked timer", 5, rd);
    apb(1'b1, 8'h00, 32'h702);
    i_partner.ext_edges(3);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk("ext clocked timer", 8, rd);
    // Staggered timer A advances once in every eight clocks, only when the low three prescaler bits are 7.
    apb(1'b1, 8'h00, 32'h1001);
    apb(1'b1, 8'h0C, 32'h0);
    repeat (78) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk("staggered timer", 10, rd);
    $display("Clock sources done");
    // Capture on timer B in each edge mode, both edges each time.
    apb(1'b1, 8'h00, 32'h0);
    cap_exp = 0;
    for (int m = 1; m <= 3; m++) begin
      apb(1'b1, 8'h44, 32'h08 | m);
      cap_edge(m, 1'b1);
      cap_edge(m, 1'b0);
    end
    $display("Capture done");
    // Compare on timer A: seven channels, three rounds; the last crosses an overflow.
    lfsr_q = lfsr_next(lfsr_q);
    t0 = 16'h4000 | lfsr_q[11:0];
    apb(1'b1, 8'h04, {16'h0000, t0});
    apb(1'b1, 8'h1C, 32'h4);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 8'h40 + 8'(4 * ch_l[k]), cfg_l[k]);
      apb(1'b1, 8'h80 + 8'(4 * ch_l[k]), {16'h0000, t0 + 16'(off_l[k])});
    end
    apb(1'b1, 8'h00, 32'h1);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, 8'h0C, (r == 2) ? 32'hFFF0 : {16'h0000, t0});
      watch(60);
      for (int k = 0; k < 7; k++) begin
        ei = (cfg_l[k] == 6 || cfg_l[k] == 7) ? (r != 1) : ((cfg_l[k] == 20) ? (r == 0) : 1);
        et = (ch_l[k] == 2) ? 2 : ((cfg_l[k] == 5) ? 1 : ((cfg_l[k] == 7) ? ((r == 1) ? 0 : r / 2 + 1) : 0));
        chk("compare irq", ei, irq_n[ch_l[k]]);
        if (ch_l[k] != 10) chk("pin changes", et, tog_n[ch_l[k]]);
      end
      chk("pin enables", 16'h00A4, cc_pin_oe & 16'h05F4);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("flags", 32'h000005F6, rd);
    apb(1'b1, 8'h14, 32'hFFFF);
    apb(1'b0, 8'h14, 32'h0);
    chk("flags cleared", 0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("disarmed", 0, rd & 32'h100);
    apb(1'b1, 8'h18, 32'h100);
    apb(1'b0, 8'h18, 32'h0);
    chk("rearmed", 32'h100, rd & 32'h100);
    $display("Compare done");
    test_done();
  end
endmodule
`default_nettype wire
